// File: core/tbr_map.vh
// Purpose: Offsets, field positions, reset values and widths of the 10BASE-T options and self-test registers.
// Assumes: Register addresses are the 5-bit management register numbers.
// Notes:   Definitions only.
`ifndef TBR_MAP_VH
`define TBR_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TBR_ADDR_W              5
`define TBR_DATA_W              16
`define TBR_OFS_RX_OPTIONS      5'h1A
`define TBR_OFS_SELFTEST        5'h1B

// ----------------------------------------------------------------------------
// Receive-options fields
// ----------------------------------------------------------------------------
`define TBR_BIT_LOW_THRESH      13
`define TBR_SQ_MSB              12
`define TBR_SQ_LSB              9
`define TBR_SQ_W                4
`define TBR_BIT_LINK_PULSE_OFF  7
`define TBR_BIT_POL_STATUS      4
`define TBR_BIT_JABBER_OFF      0
`define TBR_RX_OPTIONS_RESET    16'h0000

// ----------------------------------------------------------------------------
// Self-test fields
// ----------------------------------------------------------------------------
`define TBR_ERR_MSB             15
`define TBR_ERR_LSB             8
`define TBR_ERR_W               8
`define TBR_BIT_ERR_CAPTURE     15
`define TBR_ERR_SAT             8'hFF
`define TBR_GAP_MSB             7
`define TBR_GAP_LSB             0
`define TBR_GAP_W               8
`define TBR_GAP_RESET           8'h7D
`define TBR_GAP_SCALE_SHIFT     2
`define TBR_GAP_BYTES_W         10

`endif

// File: core/tbr_regs.v
// Purpose: 10BASE-T receive options and self-test error/gap register pair.
// Assumes: Register strobes and status events come from logic on mclk.
// Notes:   Read data is registered and valid one cycle after the read strobe.
`include "tbr_map.vh"
`timescale 1ns/1ps
`default_nettype none

module tbr_regs (
  // Clock and reset
  input  wire                          mclk,
  input  wire                          rst_n,
  // Register access
  input  wire [`TBR_ADDR_W-1:0]        reg_addr,
  input  wire                          reg_wr,
  input  wire                          reg_rd,
  input  wire [`TBR_DATA_W-1:0]        reg_wdata,
  output reg  [`TBR_DATA_W-1:0]        reg_rdata,
  output reg                           reg_rvalid,
  // Receiver status events and modes
  input  wire                          pol_inverted_evt,
  input  wire                          mode_10bte,
  input  wire                          err_cnt_wrap,
  input  wire                          prbs_err_byte,
  // Receiver and self-test controls
  output reg                           lower_rx_thresh,
  output reg  [`TBR_SQ_W-1:0]          squelch_sel,
  output reg                           link_pulse_tx_off,
  output reg                           jabber_off,
  output reg                           polarity_flag,
  output reg  [`TBR_GAP_W-1:0]         selftest_gap_quads,
  output reg  [`TBR_GAP_BYTES_W-1:0]   selftest_gap_bytes
);

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  wire                    sel_opt = (reg_addr == `TBR_OFS_RX_OPTIONS);
  wire                    sel_bst = (reg_addr == `TBR_OFS_SELFTEST);
  wire                    wr_opt  = reg_wr & sel_opt;
  wire                    wr_bst  = reg_wr & sel_bst;
  wire                    rd_opt  = reg_rd & sel_opt;
  wire                    capture = wr_bst & reg_wdata[`TBR_BIT_ERR_CAPTURE];

  reg                     jabber_bit_reg;
  reg  [`TBR_ERR_W-1:0]   err_run_reg;
  reg  [`TBR_ERR_W-1:0]   err_run_next;
  reg  [`TBR_ERR_W-1:0]   err_hold_reg;
  reg  [`TBR_DATA_W-1:0]  rdata_next;

  // ----------------------------------------------------------------------------
  // Receive-options register
  // ----------------------------------------------------------------------------
  // Only writable fields are stored, so reserved bits cannot hold a value.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lower_rx_thresh   <= 1'b0;
      squelch_sel       <= 4'h0;
      link_pulse_tx_off <= 1'b0;
      jabber_bit_reg    <= 1'b0;
    end else if (wr_opt) begin
      lower_rx_thresh   <= reg_wdata[`TBR_BIT_LOW_THRESH];
      squelch_sel       <= reg_wdata[`TBR_SQ_MSB:`TBR_SQ_LSB];
      link_pulse_tx_off <= reg_wdata[`TBR_BIT_LINK_PULSE_OFF];
      jabber_bit_reg    <= reg_wdata[`TBR_BIT_JABBER_OFF];
    end
  end

  // Jabber suppression is gated by the operating mode.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      jabber_off <= 1'b0;
    end else begin
      jabber_off <= jabber_bit_reg & mode_10bte;
    end
  end

  // ----------------------------------------------------------------------------
  // Polarity flag
  // ----------------------------------------------------------------------------
  // A new detection in the same cycle as the clearing read is kept.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      polarity_flag <= 1'b0;
    end else if (pol_inverted_evt) begin
      polarity_flag <= 1'b1;
    end else if (rd_opt) begin
      polarity_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Self-test error counter and gap
  // ----------------------------------------------------------------------------
  always @* begin
    err_run_next = err_run_reg;
    if (capture) begin
      err_run_next = 8'h00;
    end else if (prbs_err_byte) begin
      if (err_cnt_wrap || (err_run_reg != `TBR_ERR_SAT)) begin
        err_run_next = err_run_reg + 8'h01;
      end else begin
        err_run_next = `TBR_ERR_SAT;
      end
    end
  end

  // An error byte arriving with the capture write is dropped: it falls between
  // the captured window and the new one, a trade for a single-cycle capture.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_run_reg  <= 8'h00;
      err_hold_reg <= 8'h00;
    end else begin
      err_run_reg <= err_run_next;
      if (capture) begin
        err_hold_reg <= err_run_reg;
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      selftest_gap_quads <= `TBR_GAP_RESET;
      selftest_gap_bytes <= {`TBR_GAP_RESET, 2'b00};
    end else if (wr_bst) begin
      selftest_gap_quads <= reg_wdata[`TBR_GAP_MSB:`TBR_GAP_LSB];
      selftest_gap_bytes <= {reg_wdata[`TBR_GAP_MSB:`TBR_GAP_LSB], 2'b00};
    end
  end

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  always @* begin
    rdata_next = 16'h0000;
    if (sel_opt) begin
      rdata_next[`TBR_BIT_LOW_THRESH]           = lower_rx_thresh;
      rdata_next[`TBR_SQ_MSB:`TBR_SQ_LSB]       = squelch_sel;
      rdata_next[`TBR_BIT_LINK_PULSE_OFF]       = link_pulse_tx_off;
      rdata_next[`TBR_BIT_POL_STATUS]           = polarity_flag;
      rdata_next[`TBR_BIT_JABBER_OFF]           = jabber_bit_reg;
    end else if (sel_bst) begin
      rdata_next[`TBR_ERR_MSB:`TBR_ERR_LSB]     = err_hold_reg;
      rdata_next[`TBR_GAP_MSB:`TBR_GAP_LSB]     = selftest_gap_quads;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/tbr_regs_properties.sv
// Purpose: Port-level properties of the receive-options and self-test registers.
// Assumes: One mclk domain, asynchronous active-low reset.
// Notes:   Bound to tbr_regs from the bench top file.
`include "tbr_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tbr_regs_properties (
  input wire mclk, input wire rst_n, input wire [4:0] reg_addr, input wire reg_wr, input wire reg_rd,
  input wire [15:0] reg_wdata, input wire [15:0] reg_rdata, input wire reg_rvalid,
  input wire pol_inverted_evt, input wire mode_10bte, input wire err_cnt_wrap, input wire prbs_err_byte,
  input wire lower_rx_thresh, input wire [3:0] squelch_sel, input wire link_pulse_tx_off,
  input wire jabber_off, input wire polarity_flag, input wire [7:0] selftest_gap_quads,
  input wire [9:0] selftest_gap_bytes
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire wr_opt = reg_wr && (reg_addr == `TBR_OFS_RX_OPTIONS);
  sequence s_rd_opt; reg_rd && (reg_addr == `TBR_OFS_RX_OPTIONS); endsequence
  a_thresh_write: assert property (wr_opt |=> lower_rx_thresh == $past(reg_wdata[13]))
    else $error("threshold bit not stored");
  a_squelch_write: assert property (wr_opt |=> squelch_sel == $past(reg_wdata[12:9]))
    else $error("squelch code not stored");
  a_pulse_write: assert property (wr_opt |=> link_pulse_tx_off == $past(reg_wdata[7]))
    else $error("link pulse bit not stored");
  a_pol_set: assert property (pol_inverted_evt |=> polarity_flag)
    else $error("polarity event lost");
  a_pol_report: assert property (s_rd_opt |=> reg_rvalid && reg_rdata[4] == $past(polarity_flag))
    else $error("polarity bit misreported");
  a_pol_clear: assert property (s_rd_opt ##0 !pol_inverted_evt |=> !polarity_flag)
    else $error("polarity not cleared by read");
  a_jabber_gate: assert property (jabber_off |-> $past(mode_10bte))
    else $error("jabber off outside 10BASE-Te");
  a_gap_scale: assert property (selftest_gap_bytes == {selftest_gap_quads, 2'b00})
    else $error("gap bytes not four times quads");
  a_opt_reserved: assert property (reg_rvalid && $past(reg_addr) == `TBR_OFS_RX_OPTIONS |-> (reg_rdata & 16'hC16E) == 0)
    else $error("reserved option bits nonzero");
  a_unmapped_zero: assert property (reg_rd && reg_addr != 5'h1A && reg_addr != 5'h1B |=> reg_rdata == 16'h0000)
    else $error("unmapped read nonzero");
endmodule
`default_nettype wire

// File: tb/tbr_mgmt_model.sv
// Purpose: Management controller issuing register strobes.
// Assumes: Strobes change only just after a rising mclk edge.
// Notes:   Released write data is inverted so stale values never pass.
`include "tbr_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tbr_mgmt (
  input wire mclk, output var logic [4:0] reg_addr, output var logic reg_wr, output var logic reg_rd,
  output var logic [15:0] reg_wdata, input wire [15:0] reg_rdata, input wire reg_rvalid
);
  initial begin reg_addr = 5'h00; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 16'h0000; end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge mclk) begin reg_wr <= 1'b0; reg_wdata <= ~d; end
  endtask
  // A missing rvalid turns the data to unknown so the compare fails.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge mclk) reg_rd <= 1'b0;
    #1 d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
  endtask
endmodule
`default_nettype wire

// File: tb/tbr_regs_tb.sv
// Purpose: Self-checking bench for the option and self-test registers.
// Assumes: 50 MHz mclk, reset held three cycles.
// Notes:   Error counts are built from strobe pulses.
`include "tbr_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tbr_regs_tb;
  logic mclk = 0, rst_n = 0, pol_inverted_evt = 0, mode_10bte = 0, err_cnt_wrap = 0, prbs_err_byte = 0;
  wire [4:0] reg_addr; wire reg_wr, reg_rd, reg_rvalid; wire [15:0] reg_wdata, reg_rdata;
  wire lower_rx_thresh, link_pulse_tx_off, jabber_off, polarity_flag;
  wire [3:0] squelch_sel; wire [7:0] selftest_gap_quads; wire [9:0] selftest_gap_bytes;
  int fails = 0, checked = 0;
  logic [15:0] d;
  typedef struct { logic [4:0] a; logic [15:0] w; logic [15:0] e; } tbr_row_t;
  tbr_row_t rows [5] = '{'{5'h1A, 16'hFFFF, 16'h3E81}, '{5'h1A, 16'h2A80, 16'h2A80},
    '{5'h1A, 16'h1001, 16'h1001}, '{5'h1B, 16'h00FF, 16'h00FF}, '{5'h1B, 16'h0003, 16'h0003}};
  always #10 mclk = ~mclk;
  tbr_regs dut_u (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .pol_inverted_evt, .mode_10bte, .err_cnt_wrap, .prbs_err_byte, .lower_rx_thresh, .squelch_sel,
    .link_pulse_tx_off, .jabber_off, .polarity_flag, .selftest_gap_quads, .selftest_gap_bytes);
  tbr_mgmt mgmt_u (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin fails++; $display("MISMATCH t=%0t got %h expected %h", $time, got, exp); end
  endtask
  task automatic summarize;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic errs(input int n);
    repeat (n) begin @(posedge mclk) prbs_err_byte <= 1'b1; @(posedge mclk) prbs_err_byte <= 1'b0; end
  endtask
  initial begin #100000; fails++; summarize(); end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    mgmt_u.rd(5'h1A, d); chk(d, 16'h0000);
    mgmt_u.rd(5'h1B, d); chk(d, 16'h007D);
    chk({6'h00, selftest_gap_bytes}, 16'h01F4);
    foreach (rows[i]) begin
      mgmt_u.wr(rows[i].a, rows[i].w);
      mgmt_u.rd(rows[i].a, d); chk(d, rows[i].e);
      if (rows[i].a == 5'h1A) chk({2'b00, lower_rx_thresh, squelch_sel, 1'b0, link_pulse_tx_off, 7'h00},
        rows[i].e & 16'h3E80);
      else chk({6'h00, selftest_gap_bytes}, {6'h00, rows[i].e[7:0], 2'b00});
    end
    @(posedge mclk) pol_inverted_evt <= 1'b1;
    @(posedge mclk) pol_inverted_evt <= 1'b0;
    mgmt_u.rd(5'h1A, d); chk(d, 16'h1011);
    mgmt_u.rd(5'h1A, d); chk(d, 16'h1001);
    chk({15'h0000, polarity_flag | jabber_off}, 16'h0000);
    @(posedge mclk) mode_10bte <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk({15'h0000, jabber_off}, 16'h0001);
    errs(300);
    mgmt_u.wr(5'h1B, 16'h807D);
    mgmt_u.rd(5'h1B, d); chk(d, 16'hFF7D);
    errs(2);
    mgmt_u.rd(5'h1B, d); chk(d, 16'hFF7D);
    @(posedge mclk) err_cnt_wrap <= 1'b1;
    errs(256);
    mgmt_u.wr(5'h1B, 16'h807D);
    mgmt_u.rd(5'h1B, d); chk(d, 16'h027D);
    mgmt_u.wr(5'h05, 16'hFFFF);
    mgmt_u.rd(5'h05, d); chk(d, 16'h0000);
    summarize();
  end
endmodule
bind tbr_regs tbr_regs_properties chk_u (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .reg_rvalid, .pol_inverted_evt, .mode_10bte, .err_cnt_wrap, .prbs_err_byte, .lower_rx_thresh, .squelch_sel,
  .link_pulse_tx_off, .jabber_off, .polarity_flag, .selftest_gap_quads, .selftest_gap_bytes);
`default_nettype wire
